// File: src/radio_mode_seq.v
// operating mode sequencer with listen mode and avalon register slave
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "radio_seq_map.vh"
// What this block does
// - sleep to transmit passes standby, synthesizer, then transmit after lock.
// - transmit entry wakes amplifier regulator, ramps amplifier, then bit clock.
// - synthesizer lock pin goes high once the synthesizer is locked.
// - fsk transmit startup is 5 us plus 1.25 ramp plus half bit.
// - mode settled and transmit ready flags rise when transmit is ready.
// - packet mode sends preamble at once, packet after launch condition.
// - receiver startup includes a 20 us front-end delay.
// - filter delay is 21 or 34 over four times bandwidth.
// - relock after afc takes 5 over a 300 kHz loop bandwidth.
// - afc samples four bits; rssi sampling follows the integer formula.
// - receive ready flag rises once the receiver is ready.
// - bit synchronizer needs 12 preamble bits before data is valid.
// - without bit synchronizer, data is valid right at receive ready.
// - listen enable set in standby starts rc-timed idle and receive cycles.
// - no wanted signal in the window turns receiver off until next period.
// - wanted signal in the window keeps receiver on and demodulating.
// - each listen phase lasts multiplier times step, wake-up included.
// - accept rule 0 needs level only; rule 1 also needs sync match.
// - the rc oscillator is calibrated at power-up.
// - sequencer bypass jumps straight to the selected mode, except between transmit and receive, which pass synthesizer.
module radio_mode_seq #(
  parameter OSC_WAKE_CYC = (`OSC_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter FS_WAKE_CYC = (`FS_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter RC_TICK_CYC = `RC_TICK_NS / `CLK_PERIOD_NS,
  parameter RC_CAL_CYC = (`RC_CAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire CLK,
  input wire SYS_RST,
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  input wire SIGNAL_ABOVE_LIMIT,
  input wire SYNC_MATCH_FLAG,
  input wire PACKET_LAUNCH_CONDITION,
  input wire PACKET_DATA_IN,
  input wire RX_DEMOD_DATA,
  input wire SERIAL_DATA_I,
  output reg SERIAL_DATA_O,
  output reg SERIAL_DATA_OE,
  output reg TX_MOD_DATA,
  output reg BIT_CLOCK_OUT,
  output reg PA_REG_EN,
  output reg PA_RAMP_EN,
  output reg SYNTH_LOCKED,
  output reg MODE_SETTLED_FLAG,
  output reg TRANSMIT_READY_FLAG,
  output reg RECEIVE_READY_FLAG,
  output reg PACKET_ACTIVE,
  output reg [15:0] PREAMBLE_LENGTH
);
  // sequencer states
  localparam ST_SLEEP = 4'h0, ST_XO_WAKE = 4'h1, ST_STBY = 4'h2;
  localparam ST_FS_WAKE = 4'h3, ST_FS = 4'h4, ST_TX_REG = 4'h5;
  localparam ST_TX_RAMP = 4'h6, ST_TX_HALF = 4'h7, ST_TX = 4'h8;
  localparam ST_RX_ANA = 4'h9, ST_RX_CF = 4'ha, ST_RX_RSSI = 4'hb;
  localparam ST_RX_AFC = 4'hc, ST_RX_PLL = 4'hd, ST_RX = 4'he;
  // listen states
  localparam LS_OFF = 2'h0, LS_IDLE = 2'h1, LS_RX = 2'h2, LS_HOLD = 2'h3;

  reg [31:0] ctrl_reg;
  reg [15:0] bit_period_reg;
  reg [15:0] ramp_reg;
  reg [15:0] rx_bw_reg;
  reg [31:0] listen_reg;
  reg ack_reg;
  reg [3:0] state_reg, state_next;
  reg [1:0] ls_reg, ls_next;
  reg [31:0] cnt_reg;
  reg [15:0] bclk_cnt_reg;
  reg [31:0] bs_cnt_reg;
  reg data_valid_reg;
  reg [2:0] tgt;
  reg [31:0] lim;
  reg [31:0] inc;
  wire [2:0] sw_mode = ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire bypass = ctrl_reg[`CTRL_BYPASS];
  wire packet = ctrl_reg[`CTRL_PACKET];
  wire use_bitsync = packet | ctrl_reg[`CTRL_BITSYNC];
  wire [31:0] tb = {16'h0, (bit_period_reg == 16'h0) ? 16'h1 : bit_period_reg};
  wire [31:0] bw = {16'h0, (rx_bw_reg == 16'h0) ? 16'h1 : rx_bw_reg};
  wire [31:0] half_bit = (tb[16:1] == 16'h0) ? 32'h1 : {17'h0, tb[15:1]};
  wire [31:0] bw_tb = bw * tb;
  wire [31:0] rssi_units = bw_tb / `BW_SCALE;
  wire [31:0] rssi_goal = `RSSI_MULT * rssi_units * `BW_SCALE;
  wire rc_tick;
  wire rc_cal_done;
  wire ls_done;
  wire ls_start = (ls_next != ls_reg) &&
                  (ls_next == LS_IDLE || ls_next == LS_RX);
  wire accept = SIGNAL_ABOVE_LIMIT &&
                (!ctrl_reg[`CTRL_ACCEPT] || SYNC_MATCH_FLAG);
  wire [31:0] wmask = be_mask(AVS_BYTEENABLE);
  wire [31:0] cnt_sum = cnt_reg + inc;
  wire delay_done = cnt_sum >= lim;

  // byte lane mask from avalon byteenable
  function [31:0] be_mask;
    input [3:0] be;
    begin
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // settled state of a mode, used for bypass jumps and settled flag
  function [3:0] settled_state;
    input [2:0] m;
    begin
      case (m)
        `MODE_STBY: settled_state = ST_STBY;
        `MODE_FS: settled_state = ST_FS;
        `MODE_TX: settled_state = ST_TX;
        `MODE_RX: settled_state = ST_RX;
        default: settled_state = ST_SLEEP;
      endcase
    end
  endfunction

  rc_timebase #(
    .TICK_CYC(RC_TICK_CYC),
    .CAL_CYC(RC_CAL_CYC)
  ) u_rc (
    .clk(CLK),
    .rst(SYS_RST),
    .tick(rc_tick),
    .cal_done(rc_cal_done)
  );

  listen_timer u_lt (
    .clk(CLK),
    .rst(SYS_RST),
    .tick(rc_tick),
    .start(ls_start),
    .step((ls_next == LS_RX) ?
          listen_reg[`LST_RX_STEP_HI:`LST_RX_STEP_LO] :
          listen_reg[`LST_IDLE_STEP_HI:`LST_IDLE_STEP_LO]),
    .mult((ls_next == LS_RX) ?
          listen_reg[`LST_RX_MULT_HI:`LST_RX_MULT_LO] :
          listen_reg[`LST_IDLE_MULT_HI:`LST_IDLE_MULT_LO]),
    .done(ls_done)
  );

  // one wait cycle per access, answer on the second edge
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;

  // register writes and read data capture
  always @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_reg <= `RST_CTRL;
      bit_period_reg <= `RST_BIT_PERIOD;
      ramp_reg <= `RST_RAMP;
      rx_bw_reg <= `RST_RX_BW;
      listen_reg <= `RST_LISTEN;
      PREAMBLE_LENGTH <= `RST_PREAMBLE;
      ack_reg <= 1'b0;
      AVS_READDATA <= 32'h0;
    end else begin
      ack_reg <= AVS_WAITREQUEST;
      if (AVS_WRITE && ack_reg) begin
        case (AVS_ADDRESS)
          `OFS_CTRL: ctrl_reg <= (ctrl_reg & ~wmask) |
                                 (AVS_WRITEDATA & wmask);
          `OFS_BIT_PERIOD: bit_period_reg <=
            (bit_period_reg & ~wmask[15:0]) |
            (AVS_WRITEDATA[15:0] & wmask[15:0]);
          `OFS_RAMP: ramp_reg <= (ramp_reg & ~wmask[15:0]) |
            (AVS_WRITEDATA[15:0] & wmask[15:0]);
          `OFS_RX_BW: rx_bw_reg <= (rx_bw_reg & ~wmask[15:0]) |
            (AVS_WRITEDATA[15:0] & wmask[15:0]);
          `OFS_LISTEN: listen_reg <=
            (listen_reg & ~wmask) |
            (AVS_WRITEDATA & wmask);
          `OFS_PREAMBLE: PREAMBLE_LENGTH <=
            (PREAMBLE_LENGTH & ~wmask[15:0]) |
            (AVS_WRITEDATA[15:0] & wmask[15:0]);
          default: ;
        endcase
      end
      if (AVS_READ && !ack_reg) begin
        case (AVS_ADDRESS)
          `OFS_CTRL: AVS_READDATA <= {21'h0, ctrl_reg[10:0]};
          `OFS_BIT_PERIOD: AVS_READDATA <= {16'h0, bit_period_reg};
          `OFS_RAMP: AVS_READDATA <= {16'h0, ramp_reg};
          `OFS_RX_BW: AVS_READDATA <= {16'h0, rx_bw_reg};
          `OFS_LISTEN: AVS_READDATA <= {6'h0, listen_reg[25:24],
            listen_reg[23:16], 6'h0, listen_reg[9:8], listen_reg[7:0]};
          `OFS_PREAMBLE: AVS_READDATA <= {16'h0, PREAMBLE_LENGTH};
          `OFS_STATUS: AVS_READDATA <= {20'h0, ls_reg, data_valid_reg,
            rc_cal_done, SYNTH_LOCKED, RECEIVE_READY_FLAG,
            TRANSMIT_READY_FLAG, MODE_SETTLED_FLAG, state_reg};
          default: AVS_READDATA <= 32'h0;
        endcase
      end
    end
  end

  // listen mode cycle: idle, receive window, hold on a wanted signal
  always @* begin
    ls_next = ls_reg;
    case (ls_reg)
      LS_OFF:
        if (ctrl_reg[`CTRL_LISTEN_EN] && !ctrl_reg[`CTRL_LISTEN_CANCEL] &&
            state_reg == ST_STBY && rc_cal_done)
          ls_next = LS_IDLE;
      LS_IDLE:
        if (ls_done)
          ls_next = LS_RX;
      LS_RX:
        if (accept)
          ls_next = LS_HOLD;
        else if (ls_done)
          ls_next = LS_IDLE;
      LS_HOLD: ls_next = LS_HOLD;
      default: ls_next = LS_OFF;
    endcase
    if (ctrl_reg[`CTRL_LISTEN_CANCEL])
      ls_next = LS_OFF;
  end

  // target mode: listen overrides software mode, idle keeps only rc alive
  always @* begin
    if (ls_reg == LS_RX || ls_reg == LS_HOLD)
      tgt = `MODE_RX;
    else if (ls_reg == LS_IDLE)
      tgt = `MODE_SLEEP;
    else
      tgt = sw_mode;
  end

  // delay length and increment per waiting state
  always @* begin
    inc = 32'h1;
    case (state_reg)
      ST_XO_WAKE: lim = OSC_WAKE_CYC;
      ST_FS_WAKE: lim = FS_WAKE_CYC;
      ST_TX_REG: lim = `PA_REG_CYC;
      ST_TX_RAMP: lim = {16'h0, ramp_reg} + {18'h0, ramp_reg[15:2]};
      ST_TX_HALF: lim = half_bit;
      ST_RX_ANA: lim = `ANA_CYC;
      ST_RX_CF: begin
        inc = bw; // accumulate bandwidth to divide by it
        lim = ctrl_reg[`CTRL_OOK] ? `CF_NUM_OOK * `BW_SCALE :
                                    `CF_NUM_FSK * `BW_SCALE;
      end
      ST_RX_RSSI: begin
        inc = bw;
        lim = rssi_goal;
      end
      ST_RX_AFC: lim = `AFC_BITS * tb;
      ST_RX_PLL: lim = `PLLAFC_CYC;
      default: lim = 32'h0;
    endcase
  end

  // mode sequencer
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_SLEEP:
        if (tgt != `MODE_SLEEP)
          state_next = bypass ? settled_state(tgt) : ST_XO_WAKE;
      ST_XO_WAKE:
        if (tgt == `MODE_SLEEP)
          state_next = ST_SLEEP;
        else if (delay_done)
          state_next = ST_STBY;
      ST_STBY:
        if (tgt == `MODE_SLEEP)
          state_next = ST_SLEEP;
        else if (tgt != `MODE_STBY)
          state_next = bypass ? settled_state(tgt) : ST_FS_WAKE;
      ST_FS_WAKE:
        if (tgt == `MODE_SLEEP || tgt == `MODE_STBY)
          state_next = settled_state(tgt);
        else if (delay_done)
          state_next = ST_FS;
      ST_FS:
        if (tgt == `MODE_TX)
          state_next = bypass ? ST_TX : ST_TX_REG;
        else if (tgt == `MODE_RX)
          state_next = bypass ? ST_RX : ST_RX_ANA;
        else if (tgt != `MODE_FS)
          state_next = settled_state(tgt);
      ST_TX_REG, ST_TX_RAMP, ST_TX_HALF:
        if (tgt != `MODE_TX)
          state_next = ST_FS;
        else if (delay_done)
          state_next = state_reg + 4'h1; // regulator, ramp, half bit
      ST_RX_ANA, ST_RX_CF:
        if (tgt != `MODE_RX)
          state_next = ST_FS;
        else if (delay_done)
          state_next = state_reg + 4'h1;
      ST_RX_RSSI:
        if (tgt != `MODE_RX)
          state_next = ST_FS;
        else if (delay_done)
          state_next = ctrl_reg[`CTRL_AFC] ? ST_RX_AFC : ST_RX;
      ST_RX_AFC, ST_RX_PLL:
        if (tgt != `MODE_RX)
          state_next = ST_FS;
        else if (delay_done)
          state_next = (state_reg == ST_RX_AFC) ? ST_RX_PLL : ST_RX;
      ST_TX:
        if (tgt != `MODE_TX)
          state_next = (tgt == `MODE_RX) ? ST_FS : settled_state(tgt);
      ST_RX:
        if (tgt != `MODE_RX)
          state_next = (tgt == `MODE_TX) ? ST_FS : settled_state(tgt);
      default: state_next = ST_SLEEP;
    endcase
  end

  // state, delay counter and listen state registers
  always @(posedge CLK) begin
    if (SYS_RST) begin
      state_reg <= ST_SLEEP;
      ls_reg <= LS_OFF;
      cnt_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      ls_reg <= ls_next;
      cnt_reg <= (state_next != state_reg) ? 32'h0 : cnt_sum;
    end
  end

  // bit clock and bit synchronizer counters
  always @(posedge CLK) begin
    if (SYS_RST) begin
      bclk_cnt_reg <= 16'h0;
      BIT_CLOCK_OUT <= 1'b0;
      bs_cnt_reg <= 32'h0;
      data_valid_reg <= 1'b0;
    end else begin
      if (state_reg != ST_TX) begin
        bclk_cnt_reg <= 16'h0;
        BIT_CLOCK_OUT <= 1'b0; // no bit clock before ramp-up ends
      end else if ({16'h0, bclk_cnt_reg} == half_bit - 32'h1) begin
        bclk_cnt_reg <= 16'h0;
        BIT_CLOCK_OUT <= ~BIT_CLOCK_OUT;
      end else begin
        bclk_cnt_reg <= bclk_cnt_reg + 16'h1;
      end
      if (state_reg != ST_RX) begin
        bs_cnt_reg <= 32'h0;
        data_valid_reg <= 1'b0;
      end else if (!use_bitsync) begin
        data_valid_reg <= 1'b1;
      end else if (bs_cnt_reg == `BITSYNC_BITS * tb - 32'h1) begin
        data_valid_reg <= 1'b1;
      end else begin
        bs_cnt_reg <= bs_cnt_reg + 32'h1;
      end
    end
  end

  // status flags, amplifier controls and data paths
  always @(posedge CLK) begin
    if (SYS_RST) begin
      PA_REG_EN <= 1'b0;
      PA_RAMP_EN <= 1'b0;
      SYNTH_LOCKED <= 1'b0;
      MODE_SETTLED_FLAG <= 1'b0;
      TRANSMIT_READY_FLAG <= 1'b0;
      RECEIVE_READY_FLAG <= 1'b0;
      PACKET_ACTIVE <= 1'b0;
      TX_MOD_DATA <= 1'b0;
      SERIAL_DATA_O <= 1'b0;
      SERIAL_DATA_OE <= 1'b0;
    end else begin
      PA_REG_EN <= state_next >= ST_TX_REG && state_next <= ST_TX;
      PA_RAMP_EN <= state_next >= ST_TX_RAMP && state_next <= ST_TX;
      SYNTH_LOCKED <= state_next >= ST_FS;
      MODE_SETTLED_FLAG <= state_next == settled_state(tgt) &&
                           ls_next == ls_reg;
      TRANSMIT_READY_FLAG <= state_next == ST_TX;
      RECEIVE_READY_FLAG <= state_next == ST_RX;
      if (state_reg != ST_TX)
        PACKET_ACTIVE <= 1'b0;
      else if (packet && PACKET_LAUNCH_CONDITION)
        PACKET_ACTIVE <= 1'b1;
      // preamble toggles with the bit clock until the packet launches
      if (state_reg != ST_TX)
        TX_MOD_DATA <= 1'b0;
      else if (!packet)
        TX_MOD_DATA <= SERIAL_DATA_I;
      else
        TX_MOD_DATA <= PACKET_ACTIVE ? PACKET_DATA_IN : BIT_CLOCK_OUT;
      SERIAL_DATA_OE <= state_reg == ST_RX && !packet;
      SERIAL_DATA_O <= data_valid_reg & RX_DEMOD_DATA;
    end
  end
endmodule // radio_mode_seq

// File: src/radio_seq_map.vh
// register offsets, field positions, reset values and timing counts
`ifndef RADIO_SEQ_MAP_VH
`define RADIO_SEQ_MAP_VH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_BIT_PERIOD 8'h04
`define OFS_RAMP 8'h08
`define OFS_RX_BW 8'h0c
`define OFS_LISTEN 8'h10
`define OFS_PREAMBLE 8'h14
`define OFS_STATUS 8'h18

// control register fields
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 2
`define CTRL_BYPASS 3
`define CTRL_LISTEN_EN 4
`define CTRL_LISTEN_CANCEL 5
`define CTRL_PACKET 6
`define CTRL_BITSYNC 7
`define CTRL_OOK 8
`define CTRL_AFC 9
`define CTRL_ACCEPT 10

// listen register fields
`define LST_IDLE_MULT_LO 0
`define LST_IDLE_MULT_HI 7
`define LST_IDLE_STEP_LO 8
`define LST_IDLE_STEP_HI 9
`define LST_RX_MULT_LO 16
`define LST_RX_MULT_HI 23
`define LST_RX_STEP_LO 24
`define LST_RX_STEP_HI 25

// reset values
`define RST_CTRL 32'h0000_0001
`define RST_BIT_PERIOD 16'h2710
`define RST_RAMP 16'h0fa0
`define RST_RX_BW 16'h000a
`define RST_LISTEN 32'h0101_0101
`define RST_PREAMBLE 16'h0003

// operating mode codes
`define MODE_SLEEP 3'h0
`define MODE_STBY 3'h1
`define MODE_FS 3'h2
`define MODE_TX 3'h3
`define MODE_RX 3'h4

// clock and timing figures
`define CLK_PERIOD_NS 10
`define CLK_KHZ 100000
`define PA_REG_NS 5000
`define PA_REG_CYC ((`PA_REG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ANA_DELAY_NS 20000
`define ANA_CYC ((`ANA_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PLL_BW_KHZ 300
`define PLL_RELOCK_NUM 5
`define PLLAFC_CYC ((`PLL_RELOCK_NUM * `CLK_KHZ + `PLL_BW_KHZ - 1) / `PLL_BW_KHZ)
`define CF_NUM_FSK 21
`define CF_NUM_OOK 34
`define BW_SCALE (`CLK_KHZ / 4)
`define RSSI_MULT 2
`define AFC_BITS 4
`define BITSYNC_BITS 12
`define OSC_WAKE_NS 250000
`define FS_WAKE_NS 60000
`define RC_TICK_NS 64000
`define RC_CAL_NS 100000

// listen step lengths in rc ticks
`define STEP_SHORT 13'h0001
`define STEP_MID 13'h0040
`define STEP_LONG 13'h1000

`endif

// File: src/rc_timebase.v
// rc oscillator stand-in: power-up calibration then periodic tick enable
`timescale 1ns/1ps
module rc_timebase #(
  parameter TICK_CYC = 6400,
  parameter CAL_CYC = 10000
) (
  input wire clk,
  input wire rst,
  output reg tick,
  output reg cal_done
);
  reg [31:0] cnt_reg;

  // calibrate once after reset, then divide down to the rc tick
  always @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 32'h0;
      cal_done <= 1'b0;
      tick <= 1'b0;
    end else if (!cal_done) begin
      tick <= 1'b0;
      if (cnt_reg == CAL_CYC - 1) begin
        cnt_reg <= 32'h0;
        cal_done <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 32'h1;
      end
    end else if (cnt_reg == TICK_CYC - 1) begin
      cnt_reg <= 32'h0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule // rc_timebase

// File: src/listen_timer.v
// listen phase timer: multiplier times step, counted in rc ticks only
`timescale 1ns/1ps
`include "radio_seq_map.vh"
module listen_timer (
  input wire clk,
  input wire rst,
  input wire tick,
  input wire start,
  input wire [1:0] step,
  input wire [7:0] mult,
  output reg done
);
  reg [12:0] step_cnt;
  reg [7:0] mult_cnt;
  reg run;
  reg [12:0] step_len;

  // step code to tick count; code 0 behaves as the shortest step
  always @* begin
    case (step)
      2'h2: step_len = `STEP_MID;
      2'h3: step_len = `STEP_LONG;
      default: step_len = `STEP_SHORT;
    endcase
  end

  // count steps on rc ticks, pulse done after the last multiple
  always @(posedge clk) begin
    if (rst) begin
      step_cnt <= 13'h0;
      mult_cnt <= 8'h0;
      run <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      step_cnt <= 13'h0;
      mult_cnt <= (mult == 8'h0) ? 8'h1 : mult;
      run <= 1'b1;
      done <= 1'b0;
    end else if (run && tick) begin
      if (step_cnt == step_len - 13'h1) begin
        step_cnt <= 13'h0;
        mult_cnt <= mult_cnt - 8'h1;
        if (mult_cnt == 8'h1) begin
          run <= 1'b0;
          done <= 1'b1;
        end
      end else begin
        step_cnt <= step_cnt + 13'h1;
      end
    end else begin
      done <= 1'b0;
    end
  end
endmodule // listen_timer

// File: dv/radio_mode_seq_props.sv
// concurrent checks on the mode sequencer ports
`timescale 1ns/1ps
`include "radio_seq_map.vh"
module radio_mode_seq_props (
  input wire CLK,
  input wire SYS_RST,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire AVS_WAITREQUEST,
  input wire PA_REG_EN,
  input wire PA_RAMP_EN,
  input wire BIT_CLOCK_OUT,
  input wire SYNTH_LOCKED,
  input wire MODE_SETTLED_FLAG,
  input wire TRANSMIT_READY_FLAG,
  input wire RECEIVE_READY_FLAG,
  input wire PACKET_ACTIVE,
  input wire PACKET_LAUNCH_CONDITION
);
  localparam int REG_MIN = `PA_REG_CYC - 1;
  logic [15:0] reg_cnt;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // cycles with the regulator on and the ramp still off
  always @(posedge CLK) begin
    if (SYS_RST || !PA_REG_EN)
      reg_cnt <= 16'h0000;
    else if (!PA_RAMP_EN && reg_cnt != 16'hffff)
      reg_cnt <= reg_cnt + 16'h0001;
  end
  property p_wait; $rose(AVS_READ || AVS_WRITE) |->
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST; endproperty
  a_wait: assert property (p_wait)
    else $error("bus wait state count wrong");
  property p_lock_tx; TRANSMIT_READY_FLAG |-> SYNTH_LOCKED; endproperty
  a_lock_tx: assert property (p_lock_tx)
    else $error("transmit ready without lock");
  property p_reg_ramp; $rose(PA_RAMP_EN) |-> PA_REG_EN; endproperty
  a_reg_ramp: assert property (p_reg_ramp)
    else $error("ramp before regulator");
  property p_clk; $rose(BIT_CLOCK_OUT) |-> PA_RAMP_EN && PA_REG_EN; endproperty
  a_clk: assert property (p_clk)
    else $error("bit clock before ramp");
  property p_reg_min; $rose(PA_RAMP_EN) |-> reg_cnt >= REG_MIN; endproperty
  a_reg_min: assert property (p_reg_min)
    else $error("regulator delay too short");
  property p_settled; $rose(TRANSMIT_READY_FLAG) |-> MODE_SETTLED_FLAG;
  endproperty
  a_settled: assert property (p_settled)
    else $error("transmit ready without settled");
  property p_excl; !(TRANSMIT_READY_FLAG && RECEIVE_READY_FLAG); endproperty
  a_excl: assert property (p_excl)
    else $error("both ready flags high");
  property p_lock_rx; $rose(RECEIVE_READY_FLAG) |-> SYNTH_LOCKED; endproperty
  a_lock_rx: assert property (p_lock_rx)
    else $error("receive ready without lock");
  property p_packet; $rose(PACKET_ACTIVE) |->
    $past(PACKET_LAUNCH_CONDITION) && TRANSMIT_READY_FLAG; endproperty
  a_packet: assert property (p_packet)
    else $error("packet started without launch");
  c_tx: cover property ($rose(TRANSMIT_READY_FLAG));
  c_rx: cover property ($rose(RECEIVE_READY_FLAG));
  c_pkt: cover property ($rose(PACKET_ACTIVE));
endmodule // radio_mode_seq_props
bind radio_mode_seq radio_mode_seq_props u_props (.CLK, .SYS_RST, .AVS_READ,
  .AVS_WRITE, .AVS_WAITREQUEST, .PA_REG_EN, .PA_RAMP_EN, .BIT_CLOCK_OUT,
  .SYNTH_LOCKED, .MODE_SETTLED_FLAG, .TRANSMIT_READY_FLAG,
  .RECEIVE_READY_FLAG, .PACKET_ACTIVE, .PACKET_LAUNCH_CONDITION);

// File: dv/host_pins.sv
// host and radio pin model: serial data, demod stream, detector levels
`timescale 1ns/1ps
module host_pins (
  input wire CLK,
  input wire SYS_RST,
  input wire TRANSMIT_READY_FLAG,
  input wire BIT_CLOCK_OUT,
  input wire sig_en,
  input wire sync_en,
  output logic SERIAL_DATA_I,
  output logic RX_DEMOD_DATA,
  output logic SIGNAL_ABOVE_LIMIT,
  output logic SYNC_MATCH_FLAG,
  output logic PACKET_DATA_IN
);
  logic bclk_q;
  initial begin
    SERIAL_DATA_I = 1'b0;
    RX_DEMOD_DATA = 1'b0;
    SIGNAL_ABOVE_LIMIT = 1'b0;
    SYNC_MATCH_FLAG = 1'b0;
    PACKET_DATA_IN = 1'b0;
    bclk_q = 1'b0;
  end
  // idle line keeps changing; once ready, bits follow the bit clock
  always @(posedge CLK) begin
    bclk_q <= BIT_CLOCK_OUT;
    if (SYS_RST || !TRANSMIT_READY_FLAG)
      SERIAL_DATA_I <= ~SERIAL_DATA_I;
    else if (BIT_CLOCK_OUT && !bclk_q)
      SERIAL_DATA_I <= ~SERIAL_DATA_I;
    RX_DEMOD_DATA <= ~RX_DEMOD_DATA; // alternating preamble
    PACKET_DATA_IN <= ~PACKET_DATA_IN;
    SIGNAL_ABOVE_LIMIT <= sig_en;
    SYNC_MATCH_FLAG <= sig_en && sync_en;
  end
endmodule // host_pins

// File: dv/radio_mode_seq_tb.sv
// self-checking testbench for the radio mode sequencer
`timescale 1ns/1ps
module radio_mode_seq_tb;
  localparam int TX_MIN = 20 + 10 + 500 + 50 + 10;
  localparam int RX_MIN = 2000 + 21 + 40;
  logic CLK = 0;
  logic SYS_RST = 1;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic AVS_READ = 0;
  logic AVS_WRITE = 0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'hf;
  logic PACKET_LAUNCH_CONDITION = 0;
  logic sig_en = 0;
  logic sync_en = 0;
  wire [31:0] AVS_READDATA;
  wire [15:0] PREAMBLE_LENGTH;
  wire AVS_WAITREQUEST, SIGNAL_ABOVE_LIMIT, SYNC_MATCH_FLAG, PACKET_DATA_IN;
  wire RX_DEMOD_DATA, SERIAL_DATA_I, SERIAL_DATA_O, SERIAL_DATA_OE;
  wire TX_MOD_DATA, BIT_CLOCK_OUT, PA_REG_EN, PA_RAMP_EN, SYNTH_LOCKED;
  wire MODE_SETTLED_FLAG, TRANSMIT_READY_FLAG, RECEIVE_READY_FLAG;
  wire PACKET_ACTIVE;
  wire [3:0] flags = {PACKET_ACTIVE, MODE_SETTLED_FLAG, RECEIVE_READY_FLAG,
    TRANSMIT_READY_FLAG};
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
  logic [31:0] rv [7] = '{32'h1, 32'h2710, 32'h0fa0, 32'h000a,
    32'h01010101, 32'h3, 32'h0};
  logic [31:0] q;
  int errors = 0;
  int check_count = 0;
  int n;
  radio_mode_seq #(.OSC_WAKE_CYC(20), .FS_WAKE_CYC(10), .RC_TICK_CYC(4),
    .RC_CAL_CYC(5)) u_dut (.CLK, .SYS_RST, .AVS_ADDRESS, .AVS_READ,
    .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
    .AVS_WAITREQUEST, .SIGNAL_ABOVE_LIMIT, .SYNC_MATCH_FLAG,
    .PACKET_LAUNCH_CONDITION, .PACKET_DATA_IN, .RX_DEMOD_DATA,
    .SERIAL_DATA_I, .SERIAL_DATA_O, .SERIAL_DATA_OE, .TX_MOD_DATA,
    .BIT_CLOCK_OUT, .PA_REG_EN, .PA_RAMP_EN, .SYNTH_LOCKED,
    .MODE_SETTLED_FLAG, .TRANSMIT_READY_FLAG, .RECEIVE_READY_FLAG,
    .PACKET_ACTIVE, .PREAMBLE_LENGTH);
  host_pins u_host (.CLK, .SYS_RST, .TRANSMIT_READY_FLAG, .BIT_CLOCK_OUT,
    .sig_en, .sync_en, .SERIAL_DATA_I, .RX_DEMOD_DATA, .SIGNAL_ABOVE_LIMIT,
    .SYNC_MATCH_FLAG, .PACKET_DATA_IN);
  always #5 CLK = ~CLK;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string m);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= !w;
    AVS_WRITE <= w;
    for (i = 0; i < 40; i++) begin
      @(posedge CLK);
      if (AVS_WAITREQUEST === 1'b0) break;
    end
    if (i == 40) begin
      chk(1'b0, 1'b1, "bus timeout");
      end_sim();
    end
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e, "read");
  endtask
  // poll a register field until it matches, then compare
  task automatic poll(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    for (int i = 0; i < 2000; i++) begin
      bus(1'b0, a, 32'h0);
      if ((q & m) === e) break;
    end
    chk(q & m, e, "poll");
    if ((q & m) !== e) end_sim();
  endtask
  task automatic wait_bit(input int b, input int bound);
    for (n = 0; n < bound; n++) begin
      @(negedge CLK);
      if (flags[b] === 1'b1) break;
    end
    if (n == bound) begin
      chk(1'b0, 1'b1, "flag timeout");
      end_sim();
    end
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    SYS_RST <= 1'b0;
    bus(1'b1, 8'h1c, 32'hffffffff);
    for (int k = 0; k < 7; k++) rd(ra[k], 32'hffffffff, rv[k]);
    rd(8'h18, 32'h100, 32'h100);
    bus(1'b1, 8'h04, 32'd20);
    bus(1'b1, 8'h08, 32'd40);
    bus(1'b1, 8'h0c, 32'd25000);
    bus(1'b1, 8'h14, 32'd5);
    @(negedge CLK);
    chk(PREAMBLE_LENGTH, 32'd5, "preamble length");
    $display("test registers done");
    bus(1'b1, 8'h00, 32'h0);
    poll(8'h18, 32'hf, 32'h0);
    bus(1'b1, 8'h00, 32'h3);
    wait_bit(0, 3000);
    chk(n >= TX_MIN - 2 && n <= TX_MIN + 40, 1'b1, "tx time");
    chk(MODE_SETTLED_FLAG, 1'b1, "settled");
    chk(SYNTH_LOCKED, 1'b1, "lock pin");
    $display("test transmit done");
    bus(1'b1, 8'h00, 32'h4);
    wait_bit(1, 4000);
    chk(n >= RX_MIN - 2 && n <= RX_MIN + 60, 1'b1, "rx time");
    rd(8'h18, 32'h200, 32'h200);
    chk(SERIAL_DATA_OE, 1'b1, "serial data enable");
    chk(SERIAL_DATA_O, !RX_DEMOD_DATA, "rx data");
    bus(1'b1, 8'h00, 32'h2);
    bus(1'b1, 8'h00, 32'h384);
    wait_bit(1, 4000);
    chk(n >= RX_MIN + 1758 && n <= RX_MIN + 1820, 1'b1, "ook rx time");
    rd(8'h18, 32'h200, 32'h0);
    repeat (250) @(posedge CLK);
    rd(8'h18, 32'h200, 32'h200);
    $display("test receive done");
    bus(1'b1, 8'h00, 32'h43);
    wait_bit(0, 4000);
    chk(PACKET_ACTIVE, 1'b0, "packet held");
    @(posedge CLK);
    PACKET_LAUNCH_CONDITION <= 1'b1;
    wait_bit(3, 20);
    @(negedge CLK);
    chk(TX_MOD_DATA, !PACKET_DATA_IN, "packet data");
    bus(1'b1, 8'h00, 32'h1);
    PACKET_LAUNCH_CONDITION <= 1'b0;
    poll(8'h18, 32'hf, 32'h2);
    bus(1'b1, 8'h00, 32'h0c);
    wait_bit(1, 10);
    chk(n <= 5, 1'b1, "bypass time");
    $display("test packet and bypass done");
    bus(1'b1, 8'h00, 32'h1);
    poll(8'h18, 32'hf, 32'h2);
    bus(1'b1, 8'h10, 32'h020a0102);
    bus(1'b1, 8'h00, 32'h11);
    poll(8'h18, 32'hc00, 32'h400);
    poll(8'h18, 32'hc00, 32'h800);
    poll(8'h18, 32'hc00, 32'h400);
    sig_en <= 1'b1;
    poll(8'h18, 32'hc00, 32'hc00);
    bus(1'b1, 8'h00, 32'h21);
    bus(1'b1, 8'h00, 32'h01);
    poll(8'h18, 32'hc00, 32'h0);
    bus(1'b1, 8'h00, 32'h411);
    poll(8'h18, 32'hc00, 32'h800);
    poll(8'h18, 32'hc00, 32'h400);
    sync_en <= 1'b1;
    poll(8'h18, 32'hc00, 32'hc00);
    bus(1'b1, 8'h00, 32'h421);
    bus(1'b1, 8'h00, 32'h401);
    $display("test listen done");
    end_sim();
  end
endmodule // radio_mode_seq_tb
